// ---- hdl/dcc_pkg.sv ----
// package: register map, field layout and carrier types of the delay calibration control
package dcc_pkg;

  // ****************************************************************
  // register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] DCC_OFS_CONTROL = 8'h60;
  localparam logic [7:0] DCC_OFS_TARGET  = 8'h64;
  localparam logic [7:0] DCC_OFS_STATUS  = 8'h80;

  // ****************************************************************
  // field positions and widths
  // ****************************************************************
  localparam int DCC_BIT_CAL_EN    = 0;
  localparam int DCC_BIT_INT_CHECK = 8;
  localparam int DCC_BIT_CAL_RESET = 16;
  localparam int DCC_CYCLE_LSB     = 0;
  localparam int DCC_CYCLE_W       = 8;
  localparam int DCC_STEP_LSB      = 16;
  localparam int DCC_STEP_W        = 9;
  localparam int DCC_SUM_W         = 10;
  localparam int DCC_STA_MISMATCH  = 0;
  localparam int DCC_STA_ACTIVE    = 1;
  localparam int DCC_STA_BUSY      = 2;
  localparam int DCC_STA_CNT_LSB   = 8;
  localparam int DCC_CNT_W         = 8;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic                   DCC_RST_CAL_EN    = 1'b0;
  localparam logic                   DCC_RST_INT_CHECK = 1'b0;
  localparam logic                   DCC_RST_CAL_RESET = 1'b0;
  localparam logic [DCC_STEP_W-1:0]  DCC_RST_STEP      = 9'h000;
  localparam logic [DCC_CYCLE_W-1:0] DCC_RST_CYCLE     = 8'h00;
  localparam logic [DCC_CNT_W-1:0]   DCC_RST_CNT       = 8'h00;

  // ****************************************************************
  // carrier types
  // ****************************************************************
  typedef struct packed {
    logic cal_reset;
    logic int_check;
    logic cal_en;
  } dcc_control_type;

  typedef struct packed {
    logic [DCC_STEP_W-1:0]  step_delay;
    logic [DCC_CYCLE_W-1:0] cycle_delay;
  } dcc_target_type;

  // consistency checker states, gray along idle -> compare -> restart
  typedef enum logic [1:0] {
    DCC_ST_IDLE    = 2'b00,
    DCC_ST_COMPARE = 2'b01,
    DCC_ST_RESTART = 2'b11
  } dcc_state_type;

endpackage : dcc_pkg

// ---- hdl/dcc_check.sv ----
// consistency checker: compares configured delay sum against measured delay
`timescale 1ns/1ps
module dcc_check
  import dcc_pkg::*;
(
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 sys_rst,
  // configuration
  input  wire dcc_pkg::dcc_control_type ctl,
  input  wire dcc_pkg::dcc_target_type  target,
  // calibration side
  input  wire logic                 hyperframe_tick,
  input  wire logic [DCC_SUM_W-1:0] cur_delay,
  // results
  output logic                      restart,
  output logic                      mismatch,
  output logic                      busy
);

  dcc_state_type        state_ff;
  dcc_state_type        nxt_state;
  logic                 cal_en_d_ff;
  logic                 mismatch_ff;
  logic                 nxt_mismatch;
  logic [DCC_SUM_W-1:0] sum_ff;
  wire                  en_rise;
  wire                  trigger;
  wire                  live;

  // sum of the two configured fields, widened so it never wraps
  function automatic logic [DCC_SUM_W-1:0] delay_sum(input dcc_target_type t);
    delay_sum = DCC_SUM_W'(t.step_delay) + DCC_SUM_W'(t.cycle_delay);
  endfunction : delay_sum

  // ****************************************************************
  // trigger selection
  // ****************************************************************
  assign live    = ctl.cal_en & ~ctl.cal_reset;
  assign en_rise = ctl.cal_en & ~cal_en_d_ff;
  assign trigger = live & (ctl.int_check ? hyperframe_tick
                                         : en_rise);

  // ****************************************************************
  // check sequencer
  // ****************************************************************
  always_comb begin
    nxt_state    = state_ff;
    nxt_mismatch = mismatch_ff;
    unique case (state_ff)
      DCC_ST_IDLE: begin
        if (trigger) begin
          nxt_state = DCC_ST_COMPARE;
        end
      end
      DCC_ST_COMPARE: begin
        nxt_mismatch = (sum_ff != cur_delay);
        nxt_state    = (sum_ff != cur_delay) ? DCC_ST_RESTART : DCC_ST_IDLE;
      end
      DCC_ST_RESTART: begin
        nxt_state = DCC_ST_IDLE;
      end
      default: begin
        nxt_state = DCC_ST_IDLE;
      end
    endcase
    // calibration reset aborts any check in flight
    if (ctl.cal_reset) begin
      nxt_state = DCC_ST_IDLE;
    end
  end

  // state, edge history and latched sum
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_ff    <= DCC_ST_IDLE;
      cal_en_d_ff <= DCC_RST_CAL_EN;
      mismatch_ff <= 1'b0;
      sum_ff      <= '0;
    end else begin
      state_ff    <= nxt_state;
      cal_en_d_ff <= ctl.cal_en;
      mismatch_ff <= ctl.cal_reset ? 1'b0 : nxt_mismatch;
      if (trigger) begin
        sum_ff <= delay_sum(target);
      end
    end
  end

  // restart pulse only while calibration still enabled
  assign restart  = (state_ff == DCC_ST_RESTART) & live;
  assign mismatch = mismatch_ff;
  assign busy     = (state_ff != DCC_ST_IDLE);

endmodule : dcc_check

// ---- hdl/dcc_ctrl.sv ----
// top: software registers and control outputs of single-trip delay calibration
`timescale 1ns/1ps
module dcc_ctrl
  import dcc_pkg::*;
#(
  parameter bit HAS_CAL  = 1'b1,
  parameter bit IS_SLAVE = 1'b1
) (
  // clock and reset
  input  wire logic                      CLK_SYS,
  input  wire logic                      SYS_RST,
  // register port
  input  wire logic [7:0]                REG_ADDR,
  input  wire logic [31:0]               REG_WDATA,
  input  wire logic                      REG_WR,
  input  wire logic                      REG_RD,
  output logic [31:0]                    REG_RDATA,
  // calibration datapath inputs
  input  wire logic                      HYPERFRAME_TICK,
  input  wire logic [dcc_pkg::DCC_SUM_W-1:0] CUR_DELAY,
  // calibration datapath controls
  output logic                           CAL_ENABLE,
  output logic                           CAL_LOGIC_RST,
  output logic                           COMPANION_RST,
  output logic                           CAL_RESTART,
  output logic [dcc_pkg::DCC_STEP_W-1:0] STEP_DELAY,
  output logic [dcc_pkg::DCC_CYCLE_W-1:0] CYCLE_DELAY
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  dcc_control_type      ctl_ff;
  dcc_control_type      nxt_ctl;
  dcc_target_type       tgt_ff;
  dcc_target_type       nxt_tgt;
  logic [31:0]          rdata_ff;
  logic [31:0]          nxt_rdata;
  logic [DCC_CNT_W-1:0] recal_cnt_ff;
  logic [DCC_CNT_W-1:0] nxt_recal_cnt;
  logic                 chk_restart;
  logic                 chk_mismatch;
  logic                 chk_busy;
  wire                  ctl_present;
  wire                  tgt_present;
  wire                  sel_ctl;
  wire                  sel_tgt;
  wire                  sel_sta;
  wire                  wr_ctl;
  wire                  wr_tgt;
  wire [31:0]           ctl_word;
  wire [31:0]           tgt_word;
  wire [31:0]           sta_word;
  wire [31:0]           rd_mux;

  // ****************************************************************
  // build options
  // ****************************************************************
  // absent registers behave as unmapped: read zero, writes dropped
  assign ctl_present = HAS_CAL;
  assign tgt_present = HAS_CAL & IS_SLAVE;

  // ****************************************************************
  // address decode
  // ****************************************************************
  assign sel_ctl = ctl_present & (REG_ADDR == DCC_OFS_CONTROL);
  assign sel_tgt = tgt_present & (REG_ADDR == DCC_OFS_TARGET);
  assign sel_sta = ctl_present & (REG_ADDR == DCC_OFS_STATUS);
  assign wr_ctl  = REG_WR & sel_ctl;
  assign wr_tgt  = REG_WR & sel_tgt;

  // ****************************************************************
  // write side: only defined fields are captured
  // ****************************************************************
  // reserved bits are never stored, so they cannot leak back on read
  always_comb begin
    nxt_ctl = ctl_ff;
    if (wr_ctl) begin
      nxt_ctl.cal_en    = REG_WDATA[DCC_BIT_CAL_EN];
      nxt_ctl.int_check = REG_WDATA[DCC_BIT_INT_CHECK];
      nxt_ctl.cal_reset = REG_WDATA[DCC_BIT_CAL_RESET];
    end
  end

  always_comb begin
    nxt_tgt = tgt_ff;
    if (wr_tgt) begin
      nxt_tgt.step_delay  = REG_WDATA[DCC_STEP_LSB +: DCC_STEP_W];
      nxt_tgt.cycle_delay = REG_WDATA[DCC_CYCLE_LSB +: DCC_CYCLE_W];
    end
  end

  // control registers: only the system reset clears them,
  // the calibration reset bit deliberately has no path here
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      ctl_ff.cal_en    <= DCC_RST_CAL_EN;
      ctl_ff.int_check <= DCC_RST_INT_CHECK;
      ctl_ff.cal_reset <= DCC_RST_CAL_RESET;
    end else begin
      ctl_ff <= nxt_ctl;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      tgt_ff.step_delay  <= DCC_RST_STEP;
      tgt_ff.cycle_delay <= DCC_RST_CYCLE;
    end else begin
      tgt_ff <= nxt_tgt;
    end
  end

  // ****************************************************************
  // consistency checker
  // ****************************************************************
  dcc_check u_check (
    .clk_sys         (CLK_SYS),
    .sys_rst         (SYS_RST),
    .ctl             (ctl_ff),
    .target          (tgt_ff),
    .hyperframe_tick (HYPERFRAME_TICK),
    .cur_delay       (CUR_DELAY),
    .restart         (chk_restart),
    .mismatch        (chk_mismatch),
    .busy            (chk_busy)
  );

  // recalibration counter, saturating so software sees "many"
  // rather than a wrapped small number; cleared by calibration reset
  always_comb begin
    nxt_recal_cnt = recal_cnt_ff;
    if (ctl_ff.cal_reset) begin
      nxt_recal_cnt = DCC_RST_CNT;
    end else if (chk_restart && (recal_cnt_ff != {DCC_CNT_W{1'b1}})) begin
      nxt_recal_cnt = recal_cnt_ff + 8'h01;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      recal_cnt_ff <= DCC_RST_CNT;
    end else begin
      recal_cnt_ff <= nxt_recal_cnt;
    end
  end

  // ****************************************************************
  // read side
  // ****************************************************************
  // every bit not named here is reserved and reads as zero
  assign ctl_word = {15'h0000, ctl_ff.cal_reset,
                     7'h00, ctl_ff.int_check,
                     7'h00, ctl_ff.cal_en};
  assign tgt_word = {7'h00, tgt_ff.step_delay,
                     8'h00, tgt_ff.cycle_delay};
  assign sta_word = {16'h0000, recal_cnt_ff,
                     5'h00, chk_busy, CAL_ENABLE, chk_mismatch};
  assign rd_mux   = sel_ctl ? ctl_word :
                    sel_tgt ? tgt_word :
                    sel_sta ? sta_word : 32'h0000_0000;

  // read data appears in the cycle after the strobe, zero otherwise
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (REG_RD) begin
      nxt_rdata = rd_mux;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign REG_RDATA = rdata_ff;

  // ****************************************************************
  // calibration controls
  // ****************************************************************
  // reset level is direct from the register so release is immediate
  assign CAL_ENABLE    = ctl_ff.cal_en & ~ctl_ff.cal_reset;
  assign CAL_LOGIC_RST = ctl_ff.cal_reset;
  assign COMPANION_RST = ctl_ff.cal_reset;
  assign CAL_RESTART   = chk_restart;
  assign STEP_DELAY    = tgt_ff.step_delay;
  assign CYCLE_DELAY   = tgt_ff.cycle_delay;

endmodule : dcc_ctrl

// ---- dv/dcc_ctrl_checker.sv ----
// checker: port-level properties of the delay calibration control
`timescale 1ns/1ps
module dcc_ctrl_checker
  import dcc_pkg::*;
#(
  parameter bit HAS_CAL  = 1'b1,
  parameter bit IS_SLAVE = 1'b1
) (
  input wire logic                            CLK_SYS,
  input wire logic                            SYS_RST,
  input wire logic [7:0]                      REG_ADDR,
  input wire logic [31:0]                     REG_WDATA,
  input wire logic                            REG_WR,
  input wire logic                            REG_RD,
  input wire logic [31:0]                     REG_RDATA,
  input wire logic                            HYPERFRAME_TICK,
  input wire logic [dcc_pkg::DCC_SUM_W-1:0]   CUR_DELAY,
  input wire logic                            CAL_ENABLE,
  input wire logic                            CAL_LOGIC_RST,
  input wire logic                            COMPANION_RST,
  input wire logic                            CAL_RESTART,
  input wire logic [dcc_pkg::DCC_STEP_W-1:0]  STEP_DELAY,
  input wire logic [dcc_pkg::DCC_CYCLE_W-1:0] CYCLE_DELAY
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);

  // ****************************************************************
  // helper state snooped from the register port
  // ****************************************************************
  logic        chk_ff;
  logic [31:0] wd_ff;
  // absent registers take no writes, so only present ones are snooped
  wire         wr_ctl = HAS_CAL && REG_WR && (REG_ADDR == DCC_OFS_CONTROL);
  wire         wr_tgt = HAS_CAL && IS_SLAVE && REG_WR && (REG_ADDR == DCC_OFS_TARGET);

  // shadow of the periodic check bit, ports alone do not show it
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      chk_ff <= 1'b0;
    end else if (wr_ctl) begin
      chk_ff <= REG_WDATA[DCC_BIT_INT_CHECK];
    end
    wd_ff <= REG_WDATA;
  end

  // ****************************************************************
  // properties
  // ****************************************************************
  rdata_idle_a: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
    else $error("read data not zero outside read slot");
  companion_rst_a: assert property (COMPANION_RST == CAL_LOGIC_RST)
    else $error("companion reset differs from logic reset");
  enable_gated_a: assert property (CAL_LOGIC_RST |-> !CAL_ENABLE)
    else $error("calibration enabled during calibration reset");
  restart_blocked_a: assert property (CAL_LOGIC_RST |-> !CAL_RESTART)
    else $error("restart during calibration reset");
  restart_pulse_a: assert property (CAL_RESTART |=> !CAL_RESTART)
    else $error("restart longer than one cycle");
  periodic_restart_a: assert property (HYPERFRAME_TICK && chk_ff && CAL_ENABLE
    ##1 (CAL_ENABLE && CUR_DELAY != $past(STEP_DELAY) + $past(CYCLE_DELAY))
    |=> CAL_RESTART)
    else $error("mismatch on periodic check gave no restart");
  // an edge-started check sees enable low one cycle before its trigger
  edge_only_a: assert property (CAL_RESTART && !chk_ff
    |-> !$past(CAL_ENABLE, 3))
    else $error("restart without enable rise while periodic check off");
  // a system reset legally clears the fields, so its release is excluded
  target_hold_a: assert property (!$past(wr_tgt) && !$past(SYS_RST)
    |-> $stable(STEP_DELAY) && $stable(CYCLE_DELAY))
    else $error("delay fields changed without a write");
  target_write_a: assert property (wr_tgt |=> STEP_DELAY == wd_ff[24:16]
    && CYCLE_DELAY == wd_ff[7:0])
    else $error("delay fields do not follow written word");
  control_write_a: assert property (wr_ctl |=> CAL_LOGIC_RST == wd_ff[16]
    && CAL_ENABLE == (wd_ff[0] && !wd_ff[16]))
    else $error("control outputs do not follow written word");

  // main scenarios reached
  restart_seen_c: cover property (CAL_RESTART);
  cal_reset_c: cover property (CAL_LOGIC_RST && HYPERFRAME_TICK);
  periodic_c: cover property (HYPERFRAME_TICK && chk_ff && CAL_ENABLE);
endmodule : dcc_ctrl_checker

bind dcc_ctrl dcc_ctrl_checker #(.HAS_CAL(HAS_CAL), .IS_SLAVE(IS_SLAVE)) u_chk (
  .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .HYPERFRAME_TICK(HYPERFRAME_TICK), .CUR_DELAY(CUR_DELAY), .CAL_ENABLE(CAL_ENABLE),
  .CAL_LOGIC_RST(CAL_LOGIC_RST), .COMPANION_RST(COMPANION_RST),
  .CAL_RESTART(CAL_RESTART), .STEP_DELAY(STEP_DELAY), .CYCLE_DELAY(CYCLE_DELAY));

// ---- dv/testbench.sv ----
// testbench: register access and calibration check sequences
`timescale 1ns/1ps
module testbench;
  import dcc_pkg::*;
  logic                   clk, rst, wr, rd, tick;
  logic [7:0]             addr;
  logic [31:0]            wdata, rdata;
  logic [31:0]            rdata_m;
  logic [DCC_SUM_W-1:0]   cur;
  logic                   en, lrst, crst, restart;
  logic [DCC_STEP_W-1:0]  step;
  logic [DCC_CYCLE_W-1:0] cyc;
  int                     err_count, checks, n;

  dcc_ctrl dut (.CLK_SYS(clk), .SYS_RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .HYPERFRAME_TICK(tick),
    .CUR_DELAY(cur), .CAL_ENABLE(en), .CAL_LOGIC_RST(lrst), .COMPANION_RST(crst),
    .CAL_RESTART(restart), .STEP_DELAY(step), .CYCLE_DELAY(cyc));

  // master build on the same bus: target register must be absent
  dcc_ctrl #(.HAS_CAL(1'b1), .IS_SLAVE(1'b0)) dut_m (.CLK_SYS(clk), .SYS_RST(rst),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata_m),
    .HYPERFRAME_TICK(tick), .CUR_DELAY(cur), .CAL_ENABLE(), .CAL_LOGIC_RST(),
    .COMPANION_RST(), .CAL_RESTART(), .STEP_DELAY(), .CYCLE_DELAY());

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) begin wr <= 1'b1; addr <= a; wdata <= d; end
    @(posedge clk) wr <= 1'b0;
  endtask : wr_reg

  // read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk) begin rd <= 1'b1; addr <= a; end
    @(posedge clk) rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rd_chk

  // counts restart pulses; window spaces checks well beyond the busy time
  task automatic pulses(input logic [31:0] exp);
    n = 0;
    repeat (8) begin
      @(posedge clk);
      #1 if (restart === 1'b1) n++;
    end
    chk(32'(n), exp);
  endtask : pulses

  task automatic tick_chk(input logic [31:0] exp);
    @(posedge clk) tick <= 1'b1;
    @(posedge clk) tick <= 1'b0;
    pulses(exp);
  endtask : tick_chk

  task automatic end_of_test;
    $display("errors=%0d checks=%0d", err_count, checks);
    if (err_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test

  // ****************************************************************
  // clock, watchdog and main sequence
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // hang guard, well past the whole sequence
  initial begin
    #100000;
    err_count++;
    end_of_test();
  end

  initial begin
    {rst, wr, rd, tick, addr, wdata, cur} = {1'b1, 3'h0, 8'h00, 32'h0, 10'h000};
    err_count = 0;
    checks = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd_chk(DCC_OFS_CONTROL, 32'h0);
    rd_chk(DCC_OFS_TARGET, 32'h0);
    wr_reg(DCC_OFS_TARGET, 32'hFFFF_FFFF);
    rd_chk(DCC_OFS_TARGET, 32'h01FF_00FF);
    chk(rdata_m, 32'h0);
    chk({15'h0, step, cyc}, 32'h0001_FFFF);
    wr_reg(DCC_OFS_CONTROL, 32'hFFFF_FFFF);
    rd_chk(DCC_OFS_CONTROL, 32'h0001_0101);
    chk(rdata_m, 32'h0001_0101);
    chk({29'h0, lrst, crst, en}, 32'h6);
    rd_chk(DCC_OFS_TARGET, 32'h01FF_00FF);
    tick_chk(32'h0);
    rd_chk(8'h70, 32'h0);
    wr_reg(DCC_OFS_TARGET, 32'h0003_0005);
    cur <= 10'h008;
    wr_reg(DCC_OFS_CONTROL, 32'h0000_0101);
    // outputs launched at the write edge are looked at once settled
    #1 chk({29'h0, lrst, crst, en}, 32'h1);
    tick_chk(32'h0);
    @(posedge clk) cur <= 10'h009;
    tick_chk(32'h1);
    wr_reg(DCC_OFS_CONTROL, 32'h0);
    tick_chk(32'h0);
    wr_reg(DCC_OFS_CONTROL, 32'h1);
    pulses(32'h1);
    rd_chk(DCC_OFS_STATUS, 32'h0000_0203);
    tick_chk(32'h0);
    @(posedge clk) cur <= 10'h008;
    wr_reg(DCC_OFS_CONTROL, 32'h0);
    wr_reg(DCC_OFS_CONTROL, 32'h1);
    pulses(32'h0);
    rd_chk(DCC_OFS_STATUS, 32'h0000_0202);
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    rd_chk(DCC_OFS_TARGET, 32'h0);
    end_of_test();
  end
endmodule : testbench
